// ==== hdl/receiver_channel_control_regs.sv ====
// AXI4-Lite register bank for the output section: stage modes, converter control and status
// assumes datapath events are one-cycle pulses synchronous to MCLK_I
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none

module receiver_channel_control_regs (
	// clock and reset
	input  wire logic                         MCLK_I,
	input  wire logic                         RESETN_I,
	// axi4-lite write address, data and response
	input  wire logic [rxctl_pkg::ADDR_W-1:0] AWADDR_I,
	input  wire logic [2:0]                   AWPROT_I,
	input  wire logic                         AWVALID_I,
	output logic                              AWREADY_O,
	input  wire logic [31:0]                  WDATA_I,
	input  wire logic [3:0]                   WSTRB_I,
	input  wire logic                         WVALID_I,
	output logic                              WREADY_O,
	output logic [1:0]                        BRESP_O,
	output logic                              BVALID_O,
	input  wire logic                         BREADY_I,
	// axi4-lite read
	input  wire logic [rxctl_pkg::ADDR_W-1:0] ARADDR_I,
	input  wire logic [2:0]                   ARPROT_I,
	input  wire logic                         ARVALID_I,
	output logic                              ARREADY_O,
	output logic [31:0]                       RDATA_O,
	output logic [1:0]                        RRESP_O,
	output logic                              RVALID_O,
	input  wire logic                         RREADY_I,
	// interrupt
	output logic                              IRQ_O,
	// datapath status inputs
	input  wire logic [15:0][31:0]            CONV_POWER_I,
	input  wire logic [15:0]                  CONV_POWER_OVF_I,
	input  wire logic [15:0]                  CONV_POWER_DONE_I,
	input  wire logic [7:0][31:0]             STAGE_POWER_I,
	// converter settings
	output logic [15:0][3:0]                  CONV_DECIM_LOG2_O,
	output logic [15:0][2:0]                  CONV_INPUT_SEL_O,
	output logic [15:0]                       CONV_TEST_PATTERN_O,
	output logic [15:0]                       CONV_RESET_O,
	output logic [15:0]                       CONV_ENABLE_O,
	output logic [15:0][2:0]                  CONV_PHASE_O,
	output logic [15:0][8:0]                  CONV_GAIN_O,
	output logic [15:0][3:0]                  CONV_QUANT_BITS_O,
	output logic [15:0][31:0]                 CONV_FREQ_O,
	output logic [15:0]                       POWER_OVERFLOW_FLAG_O,
	output logic [15:0]                       POWER_DONE_FLAG_O,
	// transform stage settings
	output logic [7:0][1:0]                   STAGE_KIND_O,
	output logic [7:0][2:0]                   STAGE_GROUP_O,
	output logic [7:0][5:0]                   STAGE_CHAN_A_O,
	output logic [7:0][5:0]                   STAGE_CHAN_B_O,
	output logic [7:0]                        STAGE_SECOND_HALF_O,
	output logic [7:0]                        STAGE_BYPASS2_O,
	output logic [7:0]                        STAGE_COPY_HI_O,
	output logic [7:0][7:0]                   STAGE_GAIN_O
);
	import rxctl_pkg::*;

	// -----------------------------------------------------------------
	// storage
	// -----------------------------------------------------------------
	logic [31:0]  conv_ctl_r  [NUM_CONV];
	logic [31:0]  conv_freq_r [NUM_CONV];
	logic [31:0]  stage_r     [NUM_STAGE];
	logic [15:0]  ovf_flag_r;
	logic [15:0]  done_flag_r;
	logic [31:0]  irq_status_r;
	logic [31:0]  irq_mask_r;

	// -----------------------------------------------------------------
	// write channel
	// -----------------------------------------------------------------
	bus_state_t              wr_state_r;
	logic                    aw_got_r;
	logic                    w_got_r;
	logic [ADDR_W-1:0]       aw_addr_r;
	logic [31:0]             w_data_r;
	logic [3:0]              w_strb_r;

	wire logic               wr_idle   = (wr_state_r == BUS_IDLE);
	assign AWREADY_O = wr_idle && !aw_got_r;
	assign WREADY_O  = wr_idle && !w_got_r;
	assign BVALID_O  = (wr_state_r == BUS_RESP);
	assign BRESP_O   = 2'b00;

	wire logic               aw_take   = AWVALID_I && AWREADY_O;
	wire logic               w_take    = WVALID_I && WREADY_O;
	wire logic               aw_have   = aw_got_r || aw_take;
	wire logic               w_have    = w_got_r || w_take;
	wire logic               wr_do     = wr_idle && aw_have && w_have;
	wire logic [ADDR_W-1:0]  wr_addr   = aw_got_r ? aw_addr_r : AWADDR_I;
	wire logic [31:0]        wr_data   = w_got_r ? w_data_r : WDATA_I;
	wire logic [3:0]         wr_strb   = w_got_r ? w_strb_r : WSTRB_I;

	// word index decode, 64 words over 256 bytes
	wire logic [5:0]         wr_idx    = wr_addr[7:2];
	wire logic               wr_conv   = wr_do && wr_idx[5];
	wire logic [3:0]         wr_cnum   = wr_idx[4:1];
	wire logic               wr_ctl    = wr_conv && !wr_idx[0];
	wire logic               wr_freq   = wr_conv && wr_idx[0];
	wire logic               wr_stage  = wr_do && (wr_idx[5:3] == STAGE_BASE_IDX[5:3]);
	wire logic               wr_irqs   = wr_do && (wr_idx == IRQ_STATUS_IDX);
	wire logic               wr_irqm   = wr_do && (wr_idx == IRQ_MASK_IDX);
	wire logic               clr_ovf   = wr_ctl && wr_strb[1] && wr_data[OVF_BIT];
	wire logic               clr_done  = wr_ctl && wr_strb[1] && wr_data[DONE_BIT];

	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			wr_state_r <= BUS_IDLE;
			aw_got_r   <= 1'b0;
			w_got_r    <= 1'b0;
			aw_addr_r  <= '0;
			w_data_r   <= 32'h0000_0000;
			w_strb_r   <= 4'h0;
		end else if (wr_do) begin
			wr_state_r <= BUS_RESP;
			aw_got_r   <= 1'b0;
			w_got_r    <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= AWADDR_I;
			end
			if (w_take) begin
				w_got_r   <= 1'b1;
				w_data_r  <= WDATA_I;
				w_strb_r  <= WSTRB_I;
			end
			if (BVALID_O && BREADY_I) begin
				wr_state_r <= BUS_IDLE;
			end
		end
	end

	// -----------------------------------------------------------------
	// converter registers and latched power flags
	// -----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CONV; gi++) begin : g_conv
			wire logic sel     = (wr_cnum == 4'(gi));
			wire logic set_ovf = CONV_POWER_OVF_I[gi];
			wire logic set_dn  = CONV_POWER_DONE_I[gi];

			always_ff @(posedge MCLK_I) begin
				if (!RESETN_I) begin
					conv_ctl_r[gi]  <= CONV_CTL_RESET;
					conv_freq_r[gi] <= CONV_FREQ_RESET;
				end else begin
					if (wr_ctl && sel) begin
						conv_ctl_r[gi] <= merge_strb(conv_ctl_r[gi], wr_data, wr_strb, CONV_CTL_MASK);
					end
					if (wr_freq && sel) begin
						conv_freq_r[gi] <= merge_strb(conv_freq_r[gi], wr_data, wr_strb, 32'hFFFF_FFFF);
					end
				end
			end

			// a new event in the clearing cycle keeps the flag set
			always_ff @(posedge MCLK_I) begin
				if (!RESETN_I) begin
					ovf_flag_r[gi]  <= 1'b0;
					done_flag_r[gi] <= 1'b0;
				end else begin
					ovf_flag_r[gi]  <= set_ovf || (ovf_flag_r[gi] && !(clr_ovf && sel));
					done_flag_r[gi] <= set_dn || (done_flag_r[gi] && !(clr_done && sel));
				end
			end

			// decimation ratio is 1/2^(code+1)
			assign CONV_DECIM_LOG2_O[gi]   = {1'b0, conv_ctl_r[gi][BAND_LSB +: 3]} + 4'h1;
			assign CONV_INPUT_SEL_O[gi]    = conv_ctl_r[gi][INPUT_LSB +: 3];
			assign CONV_TEST_PATTERN_O[gi] = conv_ctl_r[gi][TEST_BIT];
			assign CONV_RESET_O[gi]        = conv_ctl_r[gi][RESET_BIT];
			assign CONV_ENABLE_O[gi]       = !conv_ctl_r[gi][RESET_BIT];
			assign CONV_PHASE_O[gi]        = conv_ctl_r[gi][PHASE_LSB +: 3];
			assign CONV_GAIN_O[gi]         = conv_ctl_r[gi][GAIN_LSB +: 9];
			assign CONV_QUANT_BITS_O[gi]   = 4'h1 << conv_ctl_r[gi][QUANT_LSB +: 2];
			assign CONV_FREQ_O[gi]         = conv_freq_r[gi];
		end
	endgenerate

	assign POWER_OVERFLOW_FLAG_O = ovf_flag_r;
	assign POWER_DONE_FLAG_O     = done_flag_r;

	// -----------------------------------------------------------------
	// transform stage registers and decoders
	// -----------------------------------------------------------------
	generate
		for (gi = 0; gi < NUM_STAGE; gi++) begin : g_stage
			stage_mode_if sm ();

			always_ff @(posedge MCLK_I) begin
				if (!RESETN_I) begin
					stage_r[gi] <= STAGE_RESET;
				end else if (wr_stage && (wr_idx[2:0] == 3'(gi))) begin
					stage_r[gi] <= merge_strb(stage_r[gi], wr_data, wr_strb, STAGE_MASK);
				end
			end

			assign sm.mode    = stage_r[gi][MODE_LSB +: 6];
			assign sm.gain_in = stage_r[gi][SGAIN_LSB +: 8];

			stage_mode_decoder u_dec (
				.clk_i    (MCLK_I),
				.resetn_i (RESETN_I),
				.sm       (sm.dec)
			);

			assign STAGE_KIND_O[gi]        = sm.kind;
			assign STAGE_GROUP_O[gi]       = sm.group;
			assign STAGE_CHAN_A_O[gi]      = sm.chan_a;
			assign STAGE_CHAN_B_O[gi]      = sm.chan_b;
			assign STAGE_SECOND_HALF_O[gi] = sm.second_half;
			assign STAGE_BYPASS2_O[gi]     = sm.bypass2;
			assign STAGE_COPY_HI_O[gi]     = sm.copy_hi;
			assign STAGE_GAIN_O[gi]        = sm.gain;
		end
	endgenerate

	// -----------------------------------------------------------------
	// interrupt status: done events low half, overflow events high half
	// -----------------------------------------------------------------
	wire logic [31:0] irq_events = {CONV_POWER_OVF_I, CONV_POWER_DONE_I};
	wire logic [31:0] irq_clear  = wr_irqs ? merge_strb(32'h0000_0000, wr_data, wr_strb, 32'hFFFF_FFFF)
	                                       : 32'h0000_0000;

	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			irq_status_r <= 32'h0000_0000;
			irq_mask_r   <= IRQ_MASK_RESET;
		end else begin
			irq_status_r <= irq_events | (irq_status_r & ~irq_clear);
			if (wr_irqm) begin
				irq_mask_r <= merge_strb(irq_mask_r, wr_data, wr_strb, 32'hFFFF_FFFF);
			end
		end
	end

	assign IRQ_O = |(irq_status_r & irq_mask_r);

	// -----------------------------------------------------------------
	// read channel
	// -----------------------------------------------------------------
	bus_state_t   rd_state_r;
	logic [31:0]  rd_data_r;

	wire logic        rd_take  = ARVALID_I && ARREADY_O;
	wire logic [5:0]  rd_idx   = ARADDR_I[7:2];
	wire logic [3:0]  rd_cnum  = rd_idx[4:1];
	wire logic [31:0] rd_ctl   = (conv_ctl_r[rd_cnum] & CONV_CTL_MASK)
	                           | (32'(ovf_flag_r[rd_cnum]) << OVF_BIT)
	                           | (32'(done_flag_r[rd_cnum]) << DONE_BIT);
	wire logic        rd_stage = (rd_idx[5:3] == STAGE_BASE_IDX[5:3]);
	// odd converter word reads total power, even reads control fields with the latched flags
	wire logic [31:0] rd_mux   = rd_idx[5] ? (rd_idx[0] ? CONV_POWER_I[rd_cnum] : rd_ctl)
	                           : rd_stage ? STAGE_POWER_I[rd_idx[2:0]]
	                           : (rd_idx == IRQ_STATUS_IDX) ? irq_status_r
	                           : (rd_idx == IRQ_MASK_IDX) ? irq_mask_r
	                           : 32'h0000_0000;

	assign ARREADY_O = (rd_state_r == BUS_IDLE);
	assign RVALID_O  = (rd_state_r == BUS_RESP);
	assign RDATA_O   = rd_data_r;
	assign RRESP_O   = 2'b00;

	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			rd_state_r <= BUS_IDLE;
			rd_data_r  <= 32'h0000_0000;
		end else if (rd_take) begin
			rd_state_r <= BUS_RESP;
			rd_data_r  <= rd_mux;
		end else if (RVALID_O && RREADY_I) begin
			rd_state_r <= BUS_IDLE;
		end
	end

endmodule

`default_nettype wire

// ==== hdl/rxctl_pkg.sv ====
// constants, field layouts and types for the receiver channel control registers
// assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data
`default_nettype none

package rxctl_pkg;

	// -----------------------------------------------------------------
	// register map: word indices, byte address is four times the index
	// -----------------------------------------------------------------
	localparam int          NUM_WORDS       = 64;
	localparam int          NUM_CONV        = 16;
	localparam int          NUM_STAGE       = 8;
	localparam int          ADDR_W          = 8;
	localparam logic [5:0]  IRQ_STATUS_IDX  = 6'h02;
	localparam logic [5:0]  IRQ_MASK_IDX    = 6'h03;
	localparam logic [5:0]  STAGE_BASE_IDX  = 6'h18;
	localparam logic [5:0]  CONV_BASE_IDX   = 6'h20;
	localparam logic [5:0]  CONV0_FREQ_IDX  = 6'h21;
	localparam logic [5:0]  CONV15_CTL_IDX  = 6'h3e;
	localparam logic [5:0]  CONV15_FREQ_IDX = 6'h3f;

	// -----------------------------------------------------------------
	// converter control word fields
	// -----------------------------------------------------------------
	localparam int          BAND_LSB        = 0;
	localparam int          INPUT_LSB       = 3;
	localparam int          TEST_BIT        = 6;
	localparam int          RESET_BIT       = 7;
	localparam int          PHASE_LSB       = 8;
	localparam int          OVF_BIT         = 11;
	localparam int          DONE_BIT        = 12;
	localparam int          GAIN_LSB        = 16;
	localparam int          QUANT_LSB       = 25;
	localparam logic [31:0] CONV_CTL_MASK   = 32'h07FF_07FF;
	localparam logic [31:0] CONV_CTL_RESET  = 32'h0000_0000;
	localparam logic [31:0] CONV_FREQ_RESET = 32'h0000_0000;

	// -----------------------------------------------------------------
	// transform stage word fields
	// -----------------------------------------------------------------
	localparam int          MODE_LSB        = 0;
	localparam int          SGAIN_LSB       = 8;
	localparam logic [31:0] STAGE_MASK      = 32'h0000_FF3F;
	localparam logic [31:0] STAGE_RESET     = 32'h0000_0030;
	localparam logic [31:0] IRQ_MASK_RESET  = 32'h0000_0000;

	// transform mode code boundaries
	localparam logic [5:0]  MODE_64_LAST    = 6'h0F;
	localparam logic [5:0]  MODE_32_LAST    = 6'h1F;
	localparam logic [5:0]  MODE_16_LO      = 6'h20;
	localparam logic [5:0]  MODE_16_HI      = 6'h21;
	localparam logic [5:0]  CHAN_HALF       = 6'h10;
	localparam logic [5:0]  CHAN_FULL       = 6'h20;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		KIND_OFF = 2'b00,
		KIND_64  = 2'b01,
		KIND_32  = 2'b11,
		KIND_16  = 2'b10
	} stage_kind_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_RESP = 2'b01
	} bus_state_t;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res & mask;
	endfunction

endpackage

`default_nettype wire

// ==== hdl/stage_mode_decoder.sv ====
// decodes one transform stage mode word into registered stage settings
// assumes mode and gain come straight from the stage control register
`default_nettype none

module stage_mode_decoder (
	// clock and reset
	input  wire logic   clk_i,
	input  wire logic   resetn_i,
	// stage settings
	stage_mode_if.dec   sm
);
	import rxctl_pkg::*;

	// -----------------------------------------------------------------
	// combinational decode
	// -----------------------------------------------------------------
	wire logic        is_64   = (sm.mode <= MODE_64_LAST);
	wire logic        is_32   = (sm.mode > MODE_64_LAST) && (sm.mode <= MODE_32_LAST);
	wire logic        is_16   = (sm.mode == MODE_16_LO) || (sm.mode == MODE_16_HI);
	wire logic [5:0]  k       = {3'b000, sm.mode[2:0]};
	wire logic        half2   = sm.mode[3];
	wire stage_kind_t kind_d  = is_64 ? KIND_64 : is_32 ? KIND_32 : is_16 ? KIND_16 : KIND_OFF;
	// first half gives k and k+16, second half 32-k and 16-k
	wire logic [5:0]  a64     = half2 ? 6'(CHAN_FULL - k) : k;
	wire logic [5:0]  b64     = half2 ? 6'(CHAN_HALF - k) : 6'(k + CHAN_HALF);
	// 32-channel: both outputs are the top outputs of the first butterflies
	wire logic [5:0]  a_d     = (is_64 || is_32) ? a64 : 6'h00;
	wire logic [5:0]  b_d     = is_64 ? b64 : is_32 ? a64 : 6'h00;

	// -----------------------------------------------------------------
	// registered settings
	// -----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sm.kind        <= KIND_OFF;
			sm.group       <= 3'h0;
			sm.chan_a      <= 6'h00;
			sm.chan_b      <= 6'h00;
			sm.second_half <= 1'b0;
			sm.bypass2     <= 1'b0;
			sm.copy_hi     <= 1'b0;
			sm.gain        <= 8'h00;
		end else begin
			sm.kind        <= kind_d;
			sm.group       <= (is_64 || is_32) ? sm.mode[2:0] : 3'h0;
			sm.chan_a      <= a_d;
			sm.chan_b      <= b_d;
			sm.second_half <= (is_64 || is_32) && half2;
			sm.bypass2     <= is_32;
			sm.copy_hi     <= is_16 && sm.mode[0];
			sm.gain        <= sm.gain_in;
		end
	end

endmodule

`default_nettype wire

// ==== hdl/stage_mode_if.sv ====
// carrier between the register bank and one transform stage decoder
// assumes both ends share the register bank clock
`default_nettype none

interface stage_mode_if;
	import rxctl_pkg::*;
	logic [5:0]  mode;
	logic [7:0]  gain_in;
	stage_kind_t kind;
	logic [2:0]  group;
	logic [5:0]  chan_a;
	logic [5:0]  chan_b;
	logic        second_half;
	logic        bypass2;
	logic        copy_hi;
	logic [7:0]  gain;

	modport ctl (output mode, output gain_in, input kind, input group, input chan_a, input chan_b,
		input second_half, input bypass2, input copy_hi, input gain);
	modport dec (input mode, input gain_in, output kind, output group, output chan_a, output chan_b,
		output second_half, output bypass2, output copy_hi, output gain);
endinterface

`default_nettype wire

// ==== verif/receiver_channel_control_regs_assertions.sv ====
// concurrent checks on the receiver channel control register bank
// assumes it is bound into the top module and sees only its ports
`default_nettype none
module receiver_channel_control_regs_assertions (
	// clock, reset and bus handshakes
	input wire logic             MCLK_I, RESETN_I, AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O,
	input wire logic             ARVALID_I, ARREADY_O, RVALID_O, RREADY_I,
	input wire logic [31:0]      RDATA_O,
	// converter and stage settings
	input wire logic [15:0]      CONV_POWER_OVF_I, POWER_OVERFLOW_FLAG_O, CONV_RESET_O, CONV_ENABLE_O,
	input wire logic [15:0][3:0] CONV_QUANT_BITS_O,
	input wire logic [7:0][1:0]  STAGE_KIND_O,
	input wire logic [7:0]       STAGE_SECOND_HALF_O,
	input wire logic [7:0][5:0]  STAGE_CHAN_A_O, STAGE_CHAN_B_O
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);

	// -----------------------------------------------------------------
	// properties
	// -----------------------------------------------------------------
	property p_enable; CONV_ENABLE_O == ~CONV_RESET_O; endproperty
	property p_quant; $onehot(CONV_QUANT_BITS_O[0]) && CONV_QUANT_BITS_O[0] <= 4'h8; endproperty
	property p_wr_resp; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |=> BVALID_O && !AWREADY_O; endproperty
	property p_rd_resp; ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O; endproperty
	property p_rd_hold; RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O); endproperty
	property p_ovf_set; CONV_POWER_OVF_I[3] |=> POWER_OVERFLOW_FLAG_O[3]; endproperty
	property p_ovf_clr;
		$fell(POWER_OVERFLOW_FLAG_O[3]) |-> $past(WVALID_I && WREADY_O) || $past(AWVALID_I && AWREADY_O)
			|| !$past(RESETN_I);
	endproperty
	property p_chan64;
		STAGE_KIND_O[0] == 2'b01 |-> (STAGE_SECOND_HALF_O[0] ? STAGE_CHAN_A_O[0] == STAGE_CHAN_B_O[0] + 6'h10
			: STAGE_CHAN_B_O[0] == STAGE_CHAN_A_O[0] + 6'h10);
	endproperty
	property p_chan32; STAGE_KIND_O[0] == 2'b11 |-> STAGE_CHAN_A_O[0] == STAGE_CHAN_B_O[0]; endproperty

	a_enable:  assert property (p_enable)  else $error("enable is not the inverse of reset");
	a_quant:   assert property (p_quant)   else $error("quantization not 1, 2, 4 or 8");
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	a_rd_resp: assert property (p_rd_resp) else $error("read response late");
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped before handshake");
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not latched");
	a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag cleared without write");
	a_chan64:  assert property (p_chan64)  else $error("wide mode channel pair wrong");
	a_chan32:  assert property (p_chan32)  else $error("half mode channels differ");

	c_ovf:  cover property ($fell(POWER_OVERFLOW_FLAG_O[3]));
	c_16:   cover property (STAGE_KIND_O[0] == 2'b10);
	c_hold: cover property (RVALID_O && !RREADY_I);
endmodule

bind receiver_channel_control_regs receiver_channel_control_regs_assertions chk_u (.*);
`default_nettype wire

// ==== verif/receiver_channel_control_regs_tb_top.sv ====
// self-checking bench for the receiver channel control register bank
// assumes the bank and its package are compiled first
`default_nettype none
module receiver_channel_control_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic MCLK_I, RESETN_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
	logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, IRQ_O;
	logic [7:0] AWADDR_I, ARADDR_I;
	logic [2:0] AWPROT_I, ARPROT_I;
	logic [31:0] WDATA_I, RDATA_O;
	logic [3:0] WSTRB_I;
	logic [1:0] BRESP_O, RRESP_O;
	logic [15:0][31:0] CONV_POWER_I, CONV_FREQ_O;
	logic [15:0] CONV_POWER_OVF_I, CONV_POWER_DONE_I, CONV_TEST_PATTERN_O, CONV_RESET_O, CONV_ENABLE_O;
	logic [15:0] POWER_OVERFLOW_FLAG_O, POWER_DONE_FLAG_O;
	logic [7:0][31:0] STAGE_POWER_I;
	logic [15:0][3:0] CONV_DECIM_LOG2_O, CONV_QUANT_BITS_O;
	logic [15:0][2:0] CONV_INPUT_SEL_O, CONV_PHASE_O;
	logic [15:0][8:0] CONV_GAIN_O;
	logic [7:0][1:0] STAGE_KIND_O;
	logic [7:0][2:0] STAGE_GROUP_O;
	logic [7:0][5:0] STAGE_CHAN_A_O, STAGE_CHAN_B_O;
	logic [7:0] STAGE_SECOND_HALF_O, STAGE_BYPASS2_O, STAGE_COPY_HI_O;
	logic [7:0][7:0] STAGE_GAIN_O;
	logic [31:0] seed, r, e, f;
	logic [31:0] ev [16];
	logic [5:0] m;
	logic [7:0] g;
	logic [5:0] corner [6] = '{6'h00, 6'h0F, 6'h13, 6'h20, 6'h21, 6'h35};
	int err_count, samples_checked, cycles;

	receiver_channel_control_regs dut_u (.*);

	initial begin
		MCLK_I = 1'b0;
		forever #2.5 MCLK_I = ~MCLK_I;
	end

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic [1:0] exp_kind(input logic [5:0] m);
		return (m <= 6'h0F) ? 2'b01 : (m <= 6'h1F) ? 2'b11 : (m == 6'h20 || m == 6'h21) ? 2'b10 : 2'b00;
	endfunction
	// channel pair {a, b}: 64ch k,k+16 or 32-k,16-k; 32ch both k or 32-k
	function automatic logic [11:0] exp_chan(input logic [5:0] m);
		logic [5:0] k;
		k = {3'b000, m[2:0]};
		if (m <= 6'h0F)
			return m[3] ? {6'(32 - k), 6'(16 - k)} : {k, 6'(k + 16)};
		if (m <= 6'h1F)
			return m[3] ? {6'(32 - k), 6'(32 - k)} : {k, k};
		return 12'h000;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		AWADDR_I <= a; WDATA_I <= d; WSTRB_I <= s; AWVALID_I <= 1'b1; WVALID_I <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge MCLK_I);
			if (AWVALID_I && AWREADY_O) begin ad = 1'b1; AWVALID_I <= 1'b0; end
			if (WVALID_I && WREADY_O) begin wd = 1'b1; WVALID_I <= 1'b0; end
		end
		BREADY_I <= 1'b1;
		do @(posedge MCLK_I); while (!BVALID_O);
		BREADY_I <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		ARADDR_I <= a;
		ARVALID_I <= 1'b1;
		do @(posedge MCLK_I); while (!ARREADY_O);
		ARVALID_I <= 1'b0;
		// hold ready back a cycle so the response has to wait
		@(posedge MCLK_I);
		RREADY_I <= 1'b1;
		do @(posedge MCLK_I); while (!RVALID_O);
		d = RDATA_O;
		RREADY_I <= 1'b0;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge MCLK_I) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			$display("unexpected at %0t: run did not finish", $time);
			summarize();
		end
	end

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		{RESETN_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = '0;
		{AWADDR_I, ARADDR_I, AWPROT_I, ARPROT_I, WDATA_I, WSTRB_I} = '0;
		{CONV_POWER_OVF_I, CONV_POWER_DONE_I, CONV_POWER_I, STAGE_POWER_I} = '0;
		seed = 32'h0000_3db5;
		repeat (4) @(posedge MCLK_I);
		RESETN_I <= 1'b1;
		for (int i = 0; i < 16; i++) CONV_POWER_I[i] <= rnd();
		for (int n = 0; n < 8; n++) STAGE_POWER_I[n] <= rnd();
		@(posedge MCLK_I);
		chk(CONV_ENABLE_O, 32'h0000_FFFF);
		chk(STAGE_KIND_O, 32'h0000_0000);
		chk(CONV_QUANT_BITS_O[0], 32'h0000_0001);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			ev[i] = rnd();
			wr(8'(8'h80 + 8 * i), ev[i], 4'hF);
			rd(8'(8'h80 + 8 * i), r);
			chk(r, ev[i] & 32'h07FF_07FF);
			chk(CONV_DECIM_LOG2_O[i], ev[i][2:0] + 32'h1);
			chk(CONV_INPUT_SEL_O[i], ev[i][5:3]);
			chk(CONV_TEST_PATTERN_O[i], ev[i][6]);
			chk(CONV_RESET_O[i], ev[i][7]);
			chk(CONV_ENABLE_O[i], !ev[i][7]);
			chk(CONV_PHASE_O[i], ev[i][10:8]);
			chk(CONV_GAIN_O[i], ev[i][24:16]);
			chk(CONV_QUANT_BITS_O[i], 32'h1 << ev[i][26:25]);
			f = rnd();
			wr(8'(8'h84 + 8 * i), f, 4'hF);
			rd(8'(8'h84 + 8 * i), r);
			chk(r, CONV_POWER_I[i]);
			chk(CONV_FREQ_O[i], f);
		end
		// one byte lane only
		e = ((ev[0] & 32'hFFFF_FF00) | 32'h0000_00FF) & 32'h07FF_07FF;
		wr(8'h80, 32'hFFFF_FFFF, 4'h1);
		rd(8'h80, r);
		chk(r, e);
		ev[0] = e;
		$display("test converters done");
		CONV_POWER_OVF_I <= 16'h0008;
		@(posedge MCLK_I);
		CONV_POWER_OVF_I <= 16'h0000;
		@(posedge MCLK_I);
		chk(POWER_OVERFLOW_FLAG_O[3], 1'b1);
		rd(8'h98, r);
		chk(r, (ev[3] & 32'h07FF_07FF) | 32'h0000_0800);
		rd(8'h08, r);
		chk(r, 32'h0008_0000);
		chk(IRQ_O, 1'b0);
		wr(8'h0C, 32'h0008_0000, 4'hF);
		chk(IRQ_O, 1'b1);
		wr(8'h98, ev[3] | 32'h0000_0800, 4'hF);
		chk(POWER_OVERFLOW_FLAG_O[3], 1'b0);
		chk(IRQ_O, 1'b1);
		wr(8'h08, 32'h0008_0000, 4'hF);
		chk(IRQ_O, 1'b0);
		// clear during a standing event: the set wins
		CONV_POWER_DONE_I <= 16'h0020;
		wr(8'hA8, ev[5] | 32'h0000_1000, 4'hF);
		chk(POWER_DONE_FLAG_O[5], 1'b1);
		CONV_POWER_DONE_I <= 16'h0000;
		wr(8'hA8, ev[5] | 32'h0000_1000, 4'hF);
		chk(POWER_DONE_FLAG_O[5], 1'b0);
		$display("test flags done");
		for (int j = 0; j < 16; j++) begin
			f = rnd();
			m = (j < 6) ? corner[j] : f[5:0];
			g = f[15:8];
			wr(8'(8'h60 + 4 * (j % 8)), {16'h0000, g, 2'b00, m}, 4'hF);
			// decoder settings follow the stage word one cycle later
			@(posedge MCLK_I);
			chk(STAGE_KIND_O[j % 8], exp_kind(m));
			chk({STAGE_CHAN_A_O[j % 8], STAGE_CHAN_B_O[j % 8]}, exp_chan(m));
			chk(STAGE_BYPASS2_O[j % 8], exp_kind(m) == 2'b11);
			chk(STAGE_COPY_HI_O[j % 8], m == 6'h21);
			chk(STAGE_GROUP_O[j % 8], (m <= 6'h1F) ? m[2:0] : 3'h0);
			chk(STAGE_GAIN_O[j % 8], g);
			rd(8'(8'h60 + 4 * (j % 8)), r);
			chk(r, STAGE_POWER_I[j % 8]);
		end
		$display("test stages done");
		summarize();
	end
endmodule
`default_nettype wire
